// >>> ccst_clock_checker_assertions.sv
/*
 checker for the clock select top: register, table and pin relations.
 assumes a bind onto ccst_clock_top with the same trim parameters.
*/
`timescale 1ns/1ps
module ccst_clock_checker #(
   parameter [7:0] TRIM_MAIN_330 = 8'h80,
   parameter [7:0] TRIM_SLOW_330 = 8'h80
) (
   input wire       ref_clk,
   input wire       sys_rst,
   input wire       clk_en,
   input wire       io_wr,
   input wire       io_rd,
   input wire [7:0] io_addr,
   input wire [7:0] io_wdata,
   input wire [7:0] io_rdata,
   input wire [2:0] table_select_param,
   input wire [7:0] table_addr,
   input wire [7:0] table_rdata,
   input wire [7:0] main_osc_trim,
   input wire [7:0] main_osc_gain,
   input wire       clock_output_oe_n,
   input wire       xtal_enable
);
// ----------------------------------------
// properties
// ----------------------------------------
default clocking @(posedge ref_clk); endclocking
default disable iff (sys_rst);
wire wen = io_wr & clk_en;
wire ren = io_rd & clk_en;
a_trim_write: assert property (wen && io_addr == 8'h34 |=>
   main_osc_trim == $past(io_wdata)) else $error("trim write lost");
a_gain_write: assert property (wen && io_addr == 8'h38 |=>
   main_osc_gain == $past(io_wdata)) else $error("gain write lost");
a_trim_read: assert property (ren && io_addr == 8'h34 |=>
   io_rdata == $past(main_osc_trim)) else $error("trim read wrong");
a_reserved_zero: assert property (ren && io_addr == 8'h30 |=>
   io_rdata[7:1] == 7'h00) else $error("reserved bits set");
a_power_trim: assert property (disable iff (1'b0) sys_rst |=>
   main_osc_trim == TRIM_MAIN_330) else $error("trim reset wrong");
a_table_main: assert property (clk_en && table_select_param == 3'h2
   && table_addr == 8'hFC |=> table_rdata == TRIM_MAIN_330)
   else $error("main table wrong");
a_table_slow: assert property (clk_en && table_select_param == 3'h3
   && table_addr == 8'hF8 |=> table_rdata == TRIM_SLOW_330)
   else $error("slow table wrong");
a_xtal_pin_off: assert property (wen && io_addr == 8'h32 ##1 clk_en
   |=> clock_output_oe_n == $past(io_wdata[3], 2)
   && xtal_enable == clock_output_oe_n) else $error("pin driven with crystal");
c_trim_write: cover property (wen && io_addr == 8'h34);
c_table_slow: cover property (table_select_param == 3'h3);
c_xtal_on: cover property ($rose(xtal_enable));
endmodule // ccst_clock_checker
bind ccst_clock_top ccst_clock_checker #(.TRIM_MAIN_330(TRIM_MAIN_330),
   .TRIM_SLOW_330(TRIM_SLOW_330)) i_chk (.*);

// >>> ccst_clock_top.v
/*
 clock source select and trim top: io register port, trim and gain
 registers, supervisory table lookup, source muxes and clock output pin.
 assumes oscillator and crystal activity arrive as ref_clk-synchronous ticks.
*/
`timescale 1ns/1ps
`include "ccst_consts.vh"
module ccst_clock_top #(
   parameter [7:0] TRIM_MAIN_330 = 8'h80,
   parameter [7:0] TRIM_MAIN_300 = 8'h80,
   parameter [7:0] TRIM_MAIN_285 = 8'h80,
   parameter [7:0] TRIM_MAIN_270 = 8'h80,
   parameter [7:0] TRIM_SLOW_330 = 8'h80,
   parameter [7:0] TRIM_SLOW_300 = 8'h80,
   parameter [7:0] TRIM_SLOW_285 = 8'h80,
   parameter [7:0] TRIM_SLOW_270 = 8'h80
) (
   input  wire       ref_clk,
   input  wire       sys_rst,
   input  wire       clk_en,
   input  wire       main_tick,
   input  wire       slow_tick,
   input  wire       xtal_tick,
   input  wire       ext_clock_input_pin,
   input  wire       io_wr,
   input  wire       io_rd,
   input  wire [7:0] io_addr,
   input  wire [7:0] io_wdata,
   input  wire [2:0] table_select_param,
   input  wire [7:0] table_addr,
   output reg  [7:0] io_rdata,
   output reg  [7:0] table_rdata,
   output reg  [7:0] main_osc_trim,
   output reg  [7:0] main_osc_gain,
   output reg  [7:0] slow_osc_trim,
   output reg        slow_osc_normal,
   output reg        core_clock,
   output reg        interval_timer_clock,
   output reg        capture_timer_clock,
   output reg        clock_output_pin,
   output reg        clock_output_oe_n,
   output reg        xtal_enable
);
   reg  [7:0] core_clock_source_select;
   reg  [7:0] clkio_cfg;
   reg  [7:0] osc_control_zero;
   reg  [7:0] timer_sel;
   reg        pin_q;
   reg        pin_q2;
   reg        pin_q3;
   reg        filt_q;
   reg  [1:0] filt_cnt;
   reg        ext_lvl;
   reg        ext_tick;
   reg        core_tick;
   reg        core_q;
   wire       div_clk;
   reg        next_ext;

   // ----------------------------------------
   // source tick pick, shared by the timer and clock-out muxes
   // ----------------------------------------
   function pick;
      input [1:0] sel;
      input       m;
      input       e;
      input       s;
      input       c;
      begin
         case (sel)
            `CCST_SRC_MAIN: pick = m;
            `CCST_SRC_EXT:  pick = e;
            `CCST_SRC_SLOW: pick = s;
            default:        pick = c;
         endcase
      end
   endfunction

   // ----------------------------------------
   // external path and filter
   // ----------------------------------------
   always @* begin
      if (clkio_cfg[`CCST_CLKIO_XEN])
         next_ext = xtal_tick;
      else if (clkio_cfg[`CCST_CLKIO_FBYP])
         next_ext = pin_q2 & ~pin_q3;
      else
         next_ext = (filt_cnt == 2'h3) & ~filt_q & pin_q2;
   end

   always @(posedge ref_clk) begin
      if (sys_rst) begin
         pin_q    <= 1'b0;
         pin_q2   <= 1'b0;
         pin_q3   <= 1'b0;
         filt_q   <= 1'b0;
         filt_cnt <= 2'h0;
         ext_tick <= 1'b0;
         ext_lvl  <= 1'b0;
      end else if (clk_en) begin
         pin_q    <= ext_clock_input_pin;
         pin_q2   <= pin_q;
         pin_q3   <= pin_q2;
         ext_tick <= next_ext;
         if (next_ext)
            ext_lvl <= ~ext_lvl;
         if (pin_q2 != filt_q) begin
            if (filt_cnt == 2'h3) begin
               filt_q   <= pin_q2;
               filt_cnt <= 2'h0;
            end else begin
               filt_cnt <= filt_cnt + 2'h1;
            end
         end else begin
            filt_cnt <= 2'h0;
         end
      end
   end

   // ----------------------------------------
   // core clock source and divider
   // ----------------------------------------
   always @* begin
      core_tick = core_clock_source_select[`CCST_CORE_SEL_BIT] ?
                  ext_tick : main_tick;
   end

   ccst_glitch_free_div #(.W(8)) u_div (
      .ref_clk  (ref_clk),
      .sys_rst  (sys_rst),
      .clk_en   (clk_en),
      .src_tick (core_tick),
      .speed    (osc_control_zero[2:0]),
      .div_clk  (div_clk)
   );

   // ----------------------------------------
   // register port
   // ----------------------------------------
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         core_clock_source_select <= `CCST_RST_CORE_SEL;
         clkio_cfg        <= `CCST_RST_CLKIO;
         osc_control_zero <= `CCST_RST_OSC_CTRL0;
         timer_sel        <= `CCST_RST_TIMER_SEL;
         main_osc_trim    <= TRIM_MAIN_330;
         slow_osc_trim    <= TRIM_SLOW_330;
         main_osc_gain    <= `CCST_RST_GAIN;
         io_rdata         <= 8'h00;
      end else if (clk_en) begin
         if (io_wr) begin
            if (io_addr == `CCST_OFF_CORE_SEL)
               core_clock_source_select <= {7'h00, io_wdata[0]};
            else if (io_addr == `CCST_OFF_CLKIO)
               clkio_cfg <= {3'h0, io_wdata[4:0]};
            else if (io_addr == `CCST_OFF_OSC_CTRL0)
               osc_control_zero <= {1'b0, io_wdata[6:0]};
            else if (io_addr == `CCST_OFF_TIMER_SEL)
               timer_sel <= {4'h0, io_wdata[3:0]};
            else if (io_addr == `CCST_OFF_MAIN_TRIM)
               main_osc_trim <= io_wdata;
            else if (io_addr == `CCST_OFF_SLOW_TRIM)
               slow_osc_trim <= io_wdata;
            else if (io_addr == `CCST_OFF_MAIN_GAIN)
               main_osc_gain <= io_wdata;
         end
         if (io_rd) begin
            if (io_addr == `CCST_OFF_CORE_SEL)
               io_rdata <= core_clock_source_select;
            else if (io_addr == `CCST_OFF_CLKIO)
               io_rdata <= clkio_cfg;
            else if (io_addr == `CCST_OFF_OSC_CTRL0)
               io_rdata <= osc_control_zero;
            else if (io_addr == `CCST_OFF_TIMER_SEL)
               io_rdata <= timer_sel;
            else if (io_addr == `CCST_OFF_MAIN_TRIM)
               io_rdata <= main_osc_trim;
            else if (io_addr == `CCST_OFF_SLOW_TRIM)
               io_rdata <= slow_osc_trim;
            else if (io_addr == `CCST_OFF_MAIN_GAIN)
               io_rdata <= main_osc_gain;
            else
               io_rdata <= 8'h00;
         end
      end
   end

   // ----------------------------------------
   // supervisory table lookup
   // ----------------------------------------
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         table_rdata <= 8'hFF;
      end else if (clk_en) begin
         table_rdata <= 8'hFF;
         if (table_select_param == `CCST_TBL_MAIN_ID) begin
            if (table_addr == `CCST_TBL_MAIN_BASE)
               table_rdata <= TRIM_MAIN_330;
            else if (table_addr == `CCST_TBL_MAIN_BASE + 8'h01)
               table_rdata <= TRIM_MAIN_300;
            else if (table_addr == `CCST_TBL_MAIN_BASE + 8'h02)
               table_rdata <= TRIM_MAIN_285;
            else if (table_addr == `CCST_TBL_MAIN_BASE + 8'h03)
               table_rdata <= TRIM_MAIN_270;
         end else if (table_select_param == `CCST_TBL_SLOW_ID) begin
            if (table_addr == `CCST_TBL_SLOW_BASE)
               table_rdata <= TRIM_SLOW_330;
            else if (table_addr == `CCST_TBL_SLOW_BASE + 8'h01)
               table_rdata <= TRIM_SLOW_300;
            else if (table_addr == `CCST_TBL_SLOW_BASE + 8'h02)
               table_rdata <= TRIM_SLOW_285;
            else if (table_addr == `CCST_TBL_SLOW_BASE + 8'h03)
               table_rdata <= TRIM_SLOW_270;
         end
      end
   end

   // ----------------------------------------
   // clock outputs
   // ----------------------------------------
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         core_clock           <= 1'b0;
         core_q               <= 1'b0;
         interval_timer_clock <= 1'b0;
         capture_timer_clock  <= 1'b0;
         clock_output_pin     <= 1'b0;
         clock_output_oe_n    <= 1'b0;
         xtal_enable          <= 1'b0;
         slow_osc_normal      <= 1'b0;
      end else begin
         if (clk_en) begin
            slow_osc_normal <= osc_control_zero[`CCST_SLOW_NORMAL];
            core_clock <= div_clk;
            core_q     <= div_clk & ~core_clock;
            interval_timer_clock <= pick(timer_sel[1:0], main_tick,
               ext_tick, slow_tick, core_q);
            capture_timer_clock <= pick(timer_sel[3:2], main_tick,
               ext_tick, slow_tick, main_tick);
            clock_output_pin <= pick(clkio_cfg[1:0], main_tick,
               ext_lvl, slow_tick, div_clk);
            clock_output_oe_n <= clkio_cfg[`CCST_CLKIO_XEN];
            xtal_enable <= clkio_cfg[`CCST_CLKIO_XEN];
         end
      end
   end
endmodule // ccst_clock_top

// >>> ccst_consts.vh
/*
 clock source select and trim: register offsets, field positions, reset
 values, table locations and clock select codes. assumes a single 200 MHz
 ref_clk domain and an 8-bit io register port.
*/
// What this block does
// - two oscillators exist: main nominal 24 MHz, slow nominal 32 kHz.
// - main trim loads the 3.30V trim value at power on.
// - main trim register lives at io 0x34; firmware writes matching trim.
// - table two returns main trims for four voltages in FCh..FFh.
// - table three returns slow trims for four voltages in F8h..FBh.
// - slow oscillator runs in suspend and clocks power-up/down logic.
// - slow oscillator selectable for interval and capture timer clocks.
// - slow oscillator has low-power and normal accuracy settings.
// - external path takes crystal when enabled, else the clock pin.
// - external clock passes a bypassable fast-transient filter.
// - cpu, interval and capture clock selects are independent.
// - cpu clock from ext or main, then power-of-two divider.
// - clock output pin drives one selectable source unless crystal uses it.
// - 0x30 bit 0 selects cpu source: 0 main, 1 external; reset 0.
// - speed code divides: 0:8 1:4 2:2 4:16 5:32 6:128; 3,7 reserved.
// - clock-out select: 00 main, 01 ext, 10 slow, 11 cpu clock.
`ifndef CCST_CONSTS_VH
`define CCST_CONSTS_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define CCST_OFF_CORE_SEL   8'h30
`define CCST_OFF_TIMER_SEL  8'h31
`define CCST_OFF_CLKIO      8'h32
`define CCST_OFF_MAIN_TRIM  8'h34
`define CCST_OFF_SLOW_TRIM  8'h36
`define CCST_OFF_MAIN_GAIN  8'h38
`define CCST_OFF_OSC_CTRL0  8'hE0
// ----------------------------------------
// field positions
// ----------------------------------------
`define CCST_CORE_SEL_BIT   0
`define CCST_CLKIO_XSEL     4
`define CCST_CLKIO_XEN      3
`define CCST_CLKIO_FBYP     2
`define CCST_SLOW_NORMAL    6
// ----------------------------------------
// reset values
// ----------------------------------------
`define CCST_RST_CORE_SEL   8'h00
`define CCST_RST_CLKIO      8'h00
`define CCST_RST_OSC_CTRL0  8'h00
`define CCST_RST_TIMER_SEL  8'h00
`define CCST_RST_GAIN       8'h40
// ----------------------------------------
// table locations
// ----------------------------------------
`define CCST_TBL_MAIN_BASE  8'hFC
`define CCST_TBL_SLOW_BASE  8'hF8
`define CCST_TBL_MAIN_ID    3'h2
`define CCST_TBL_SLOW_ID    3'h3
// ----------------------------------------
// clock select codes
// ----------------------------------------
`define CCST_SRC_MAIN       2'h0
`define CCST_SRC_EXT        2'h1
`define CCST_SRC_SLOW       2'h2
`define CCST_SRC_CORE       2'h3
`endif

// >>> ccst_ext_source.sv
/*
 external clock source: pin toggling at a set half period, crystal
 ticks while the crystal is enabled. assumes the 200 MHz ref_clk.
*/
`timescale 1ns/1ps
module ccst_ext_source (
   input  wire       ref_clk,
   input  wire       run,
   input  wire       xtal_enable,
   input  wire [7:0] half,
   output reg        pin,
   output reg        xtal_tick
);
// ----------------------------------------
// source
// ----------------------------------------
reg [7:0] cnt = 8'h00;
initial pin = 1'b0;
initial xtal_tick = 1'b0;
always @(posedge ref_clk) begin
   xtal_tick <= run && xtal_enable && cnt == 8'h00 && pin;
   if (!run) begin // idle low between bursts
      cnt <= 8'h00;
      pin <= 1'b0;
   end else if (cnt >= half - 8'h01) begin // half 5 up: at most 20 MHz
      cnt <= 8'h00;
      pin <= ~pin;
   end else
      cnt <= cnt + 8'h01;
end
endmodule // ccst_ext_source

// >>> ccst_glitch_free_div.v
/*
 glitch-free divided clock for the core: takes a source enable pulse
 and divides it by a power of two, switching only at the low phase.
 assumes clock source activity arrives as one-cycle ref_clk enables.
*/
`timescale 1ns/1ps
module ccst_glitch_free_div #(
   parameter W = 8
) (
   input  wire       ref_clk,
   input  wire       sys_rst,
   input  wire       clk_en,
   input  wire       src_tick,
   input  wire [2:0] speed,
   output reg        div_clk
);
   reg [W-1:0] cnt;
   reg [2:0]   live_speed;
   reg [7:0]   half;

   // ----------------------------------------
   // half-period lookup
   // ----------------------------------------
   function [7:0] half_of;
      input [2:0] code;
      begin
         case (code)
            3'h1:    half_of = 8'h02;
            3'h2:    half_of = 8'h01;
            3'h4:    half_of = 8'h08;
            3'h5:    half_of = 8'h10;
            3'h6:    half_of = 8'h40;
            default: half_of = 8'h04;
         endcase
      end
   endfunction

   always @* begin
      half = half_of(live_speed);
   end

   // ----------------------------------------
   // divider, speed taken only at end of low
   // ----------------------------------------
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         cnt        <= {W{1'b0}};
         div_clk    <= 1'b0;
         live_speed <= 3'h0;
      end else if (clk_en && src_tick) begin
         if (cnt + 1'b1 >= half[W-1:0]) begin
            cnt     <= {W{1'b0}};
            div_clk <= ~div_clk;
            if (!div_clk)
               live_speed <= speed;
         end else begin
            cnt <= cnt + 1'b1;
         end
      end
   end
endmodule // ccst_glitch_free_div

// >>> tb_clock_source_select_and_trim.sv
/*
 self-checking bench for the clock select top with a register model.
 assumes the external source model drives the clock pin.
*/
`timescale 1ns/1ps
module tb_clock_source_select_and_trim;
// ----------------------------------------
// signals and model
// ----------------------------------------
reg        ref_clk = 0, sys_rst = 1, clk_en = 1, run = 0, oq = 0;
reg        main_tick = 0, slow_tick = 0, io_wr = 0, io_rd = 0;
reg  [7:0] io_addr = 0, io_wdata = 0, half = 8'h06, table_addr = 0;
reg  [2:0] table_select_param = 0;
wire [7:0] io_rdata, table_rdata;
wire [7:0] mt, mg, st;
wire       core_clock, itc, ctc, cop, oe_n, xt, xtal_tick, pin, sn;
logic [7:0] mdl [256];
logic [7:0] ra [8] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h36, 8'h38,
                       8'hE0};
logic [7:0] tv [9] = '{8'hA1, 8'hA2, 8'hA3, 8'h80, 8'hB1, 8'hB2,
                       8'h80, 8'h80, 8'hFF};
int ht [8] = '{4, 2, 1, 4, 8, 16, 64, 4};
int errors = 0, n_compared = 0, cyc = 0, nm, ns, ni, nc, no, k, d, e;
ccst_clock_top #(.TRIM_MAIN_330(8'hA1), .TRIM_MAIN_300(8'hA2),
   .TRIM_MAIN_285(8'hA3), .TRIM_SLOW_330(8'hB1), .TRIM_SLOW_300(8'hB2))
i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
   .main_tick(main_tick), .slow_tick(slow_tick), .xtal_tick(xtal_tick),
   .ext_clock_input_pin(pin), .io_wr(io_wr), .io_rd(io_rd),
   .io_addr(io_addr), .io_wdata(io_wdata), .table_addr(table_addr),
   .table_select_param(table_select_param), .io_rdata(io_rdata),
   .table_rdata(table_rdata), .main_osc_trim(mt), .main_osc_gain(mg),
   .slow_osc_trim(st), .slow_osc_normal(sn), .core_clock(core_clock),
   .interval_timer_clock(itc), .capture_timer_clock(ctc),
   .clock_output_pin(cop), .clock_output_oe_n(oe_n), .xtal_enable(xt));
ccst_ext_source i_src (.ref_clk(ref_clk), .run(run), .xtal_enable(xt),
   .half(half), .pin(pin), .xtal_tick(xtal_tick));
initial forever #2.5 ref_clk = ~ref_clk;
always @(posedge ref_clk) begin
   main_tick <= ~main_tick;
   slow_tick <= !slow_tick && ($urandom % 4) == 0;
   cyc++;
   nm += main_tick;
   ns += slow_tick;
   ni += itc;
   nc += ctc;
   no += cop && !oq;
   oq = cop;
   if (cyc > 20000) begin
      errors++;
      stop_test();
   end
end
// ----------------------------------------
// tasks
// ----------------------------------------
task chk(input logic [31:0] g, input logic [31:0] x);
   n_compared++;
   if (g !== x) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
   end
endtask
function int near(int g, int x);
   return (g > x - 3 && g < x + 3) ? x : g;
endfunction
task wr(input [7:0] a, input [7:0] v);
   @(posedge ref_clk);
   io_wr <= 1;
   io_addr <= a;
   io_wdata <= v;
   @(posedge ref_clk);
   io_wr <= 0;
   mdl[a] = v & (a == 8'h30 ? 8'h01 : a == 8'h31 ? 8'h0F :
                 a == 8'h32 ? 8'h1F : a == 8'hE0 ? 8'h7F :
                 a == 8'h33 ? 8'h00 : 8'hFF);
endtask
task rd(input [7:0] a);
   @(posedge ref_clk);
   io_rd <= 1;
   io_addr <= a;
   @(posedge ref_clk);
   io_rd <= 0;
   #1 chk(io_rdata, mdl[a]);
endtask
task meas(output int n);
   int t;
   #1;
   for (t = 0; t < 900 && core_clock !== 1'b0; t++) @(posedge ref_clk) #1;
   for (t = 0; t < 900 && core_clock !== 1'b1; t++) @(posedge ref_clk) #1;
   for (n = 0; n < 900 && core_clock === 1'b1; n++) @(posedge ref_clk) #1;
endtask
task win;
   @(posedge ref_clk);
   {nm, ns, ni, nc, no} = 160'h0;
   repeat (300) @(posedge ref_clk);
endtask
task stop_test;
   $display("compared %0d errors %0d", n_compared, errors);
   if (errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
   else
      $display("SIMULATION FAILED");
   $finish;
endtask
// ----------------------------------------
// tests
// ----------------------------------------
initial begin
   k = $urandom(32'h9E08CA97);
   foreach (mdl[i]) mdl[i] = 8'h00;
   mdl[8'h34] = 8'hA1;
   mdl[8'h36] = 8'hB1;
   mdl[8'h38] = 8'h40;
   repeat (8) @(posedge ref_clk);
   sys_rst <= 0;
   for (k = 0; k < 8; k++) begin
      rd(ra[k]);
      wr(ra[k], 8'($urandom));
      rd(ra[k]);
   end
   for (k = 0; k < 2; k++) begin
      wr(8'h38, k ? 8'hFF : 8'h40);
      rd(8'h38);
   end
   chk({mt, mg, st}, {mdl[8'h34], mdl[8'h38], mdl[8'h36]});
   e = mdl[8'h34];
   @(posedge ref_clk);
   clk_en <= 0;
   wr(8'h34, 8'h5A);
   clk_en <= 1;
   mdl[8'h34] = 8'(e);
   rd(8'h34);
   wr(8'h30, 8'h00);
   for (k = 0; k < 9; k++) begin
      @(posedge ref_clk);
      table_select_param <= k < 4 ? 3'h2 : k < 8 ? 3'h3 : 3'h5;
      table_addr <= 8'hF8 + 8'((k + 4) % 8);
      @(posedge ref_clk);
      #1 chk(table_rdata, tv[k]);
   end
   for (k = 0; k < 8; k++) begin
      wr(8'hE0, {1'b0, k[0], 3'h0, k[2:0]});
      meas(d);
      meas(d);
      chk(d, 2 * ht[k]);
      chk(sn, k[0]);
   end
   for (k = 0; k < 3; k++) begin
      wr(8'h31, k == 2 ? 8'h07 : k ? 8'h08 : 8'h02);
      win();
      e = k == 2 ? 300 / (4 * ht[7]) : k ? nm : ns;
      d = k == 2 ? 0 : k ? ns : nm;
      chk(near(ni, e), e);
      chk(near(nc, d), d);
   end
   run <= 1;
   for (k = 0; k < 5; k++) begin
      half <= k < 3 ? 8'h06 : k == 3 ? 8'h03 : 8'h05;
      wr(8'h32, k == 3 ? 8'h01 : k > 2 ? 8'h05 : 8'h04 + 8'(k));
      win();
      e = k == 0 ? nm : k == 2 ? ns : k == 3 ? 0 : 300 / (2 * half);
      d = near(no, e) == e || near(2 * no, e) == e ? e : no;
      chk(d, e);
   end
   half <= 8'h06;
   wr(8'h32, 8'h0C);
   wr(8'h30, 8'h01);
   rd(8'h30);
   chk(oe_n, 1'b1);
   chk(xt, 1'b1);
   wr(8'hE0, 8'h02);
   meas(d);
   meas(d);
   chk(d, 12);
   stop_test();
end
endmodule // tb_clock_source_select_and_trim
